// ### verilog/sml_pkg.sv
package sml_pkg;

  // Width of the device-mode strap field.
  localparam int unsigned SML_MODE_W = 5;

  // Mode codes that the decoder recognises.
  localparam logic [4:0] SML_MODE_PDOWN     = 5'h08;
  localparam logic [4:0] SML_MODE_FORCE_GIG = 5'h0a;
  localparam logic [4:0] SML_MODE_FORCE_FST = 5'h0b;
  localparam logic [4:0] SML_MODE_AN_ALL_S  = 5'h10;
  localparam logic [4:0] SML_MODE_AN_ALL_M  = 5'h11;
  localparam logic [4:0] SML_MODE_AN_GIG_S  = 5'h12;
  localparam logic [4:0] SML_MODE_AN_GIG_M  = 5'h13;
  localparam logic [4:0] SML_MODE_AN_FST    = 5'h14;
  localparam logic [4:0] SML_MODE_AN_FSTFD  = 5'h15;
  localparam logic [4:0] SML_MODE_EEE_S     = 5'h18;
  localparam logic [4:0] SML_MODE_EEE_M     = 5'h19;

  // Cycles after reset release before the synchronised straps are used.
  localparam logic [1:0] SML_SETTLE_CYC = 2'h2;

  // Register byte offsets, decoded on the low address bits.
  localparam int unsigned SML_ADDR_W     = 8;
  localparam logic [7:0]  SML_OFS_STATUS = 8'h00;
  localparam logic [7:0]  SML_OFS_CFG    = 8'h04;
  localparam logic [7:0]  SML_OFS_PDOWN  = 8'h08;

  // Status register field positions.
  localparam int unsigned SML_ST_MODE_LSB = 0;
  localparam int unsigned SML_ST_VALID    = 5;
  localparam int unsigned SML_ST_LATCHED  = 6;

  // Reset value of the mode code, and the word transfer size.
  localparam logic [4:0] SML_MODE_RST  = 5'h00;
  localparam logic [2:0] SML_HSIZE_WORD = 3'h2;

  // Decoded per-port operating settings, most significant field first.
  typedef struct packed {
    logic mode_valid;       // Code is one of the defined modes.
    logic power_down;       // Ports held in software power-down.
    logic pll_enable;       // Internal PLL kept running.
    logic aneg_enable;      // Auto-negotiation enabled.
    logic force_gig;        // Forced 1000 Mb/s full duplex.
    logic force_fast;       // Forced 100 Mb/s full duplex.
    logic force_master;     // Forced link acts as clock master.
    logic auto_crossover;   // Automatic crossover enabled.
    logic eee_adv;          // Energy-efficient operation advertised.
    logic gig_full_duplex;  // Advertise 1000 full duplex.
    logic gig_half_duplex;  // Advertise 1000 half duplex (never set).
    logic multi_port;       // Multi-port preference (else single).
    logic fast_full_duplex; // Advertise 100 full duplex.
    logic fast_half_duplex; // Advertise 100 half duplex.
    logic ten_full_duplex;  // Advertise 10 full duplex.
    logic ten_half_duplex;  // Advertise 10 half duplex.
    logic pause_adv;        // Advertise asymmetric and symmetric pause.
    logic cat3_cable;       // Category-3 cable for 10 Mb/s (else cat5).
  } sml_cfg_s;

  // Width of the settings vector as read over the bus.
  localparam int unsigned SML_CFG_W = $bits(sml_cfg_s);

endpackage

// ### verilog/sml_cfg_if.sv
`timescale 1ns/10ps
// Carries a mode code to the decoder and the decoded settings back.
interface sml_cfg_if;
  import sml_pkg::*;

  logic     [SML_MODE_W-1:0] mode; // Mode code to decode.
  sml_cfg_s                  cfg;  // Settings for that code.

  // Decoder side.
  modport dec (
    input  mode,
    output cfg
  );

  // Side that owns the latched code.
  modport user (
    output mode,
    input  cfg
  );
endinterface

// ### verilog/sml_mode_decode.sv
`timescale 1ns/10ps
// Turns a five-bit mode code into the per-port operating settings.
module sml_mode_decode (
  sml_cfg_if.dec bus
);
  import sml_pkg::*;

  // Base advertisement set shared by all the auto-negotiation modes.
  sml_cfg_s an_base;
  // Result of the code lookup.
  sml_cfg_s cfg_c;

  // Every negotiating mode enables negotiation, pause and crossover.
  always_comb begin
    an_base                = '0;
    an_base.mode_valid     = 1'b1;
    an_base.pll_enable     = 1'b1;
    an_base.aneg_enable    = 1'b1;
    an_base.auto_crossover = 1'b1;
    an_base.pause_adv      = 1'b1;
  end

  // Code lookup; 1000 half duplex is left clear in every branch.
  always_comb begin
    cfg_c = an_base;
    unique case (bus.mode)
      SML_MODE_PDOWN: begin
        // Ports powered down while the PLL keeps running.
        cfg_c                = '0;
        cfg_c.mode_valid     = 1'b1;
        cfg_c.power_down     = 1'b1;
        cfg_c.pll_enable     = 1'b1;
      end
      SML_MODE_FORCE_GIG, SML_MODE_FORCE_FST: begin
        // Forced link: no negotiation, crossover or EEE.
        cfg_c                = '0;
        cfg_c.mode_valid     = 1'b1;
        cfg_c.pll_enable     = 1'b1;
        cfg_c.force_gig      = ~bus.mode[0];
        cfg_c.force_master   = ~bus.mode[0];
        cfg_c.force_fast     = bus.mode[0];
      end
      SML_MODE_AN_ALL_S, SML_MODE_AN_ALL_M: begin
        // Everything but EEE, category-3 cable for 10 Mb/s.
        cfg_c.gig_full_duplex  = 1'b1;
        cfg_c.multi_port       = bus.mode[0];
        cfg_c.fast_full_duplex = 1'b1;
        cfg_c.fast_half_duplex = 1'b1;
        cfg_c.ten_full_duplex  = 1'b1;
        cfg_c.ten_half_duplex  = 1'b1;
        cfg_c.cat3_cable       = 1'b1;
      end
      SML_MODE_AN_GIG_S, SML_MODE_AN_GIG_M: begin
        // Gigabit full duplex only.
        cfg_c.gig_full_duplex  = 1'b1;
        cfg_c.multi_port       = bus.mode[0];
      end
      SML_MODE_AN_FST, SML_MODE_AN_FSTFD: begin
        // 100 Mb/s full duplex, plus half duplex for the even code.
        cfg_c.fast_full_duplex = 1'b1;
        cfg_c.fast_half_duplex = ~bus.mode[0];
      end
      SML_MODE_EEE_S, SML_MODE_EEE_M: begin
        // Recommended default sets, with EEE and cat5 cable.
        cfg_c.gig_full_duplex  = 1'b1;
        cfg_c.multi_port       = bus.mode[0];
        cfg_c.eee_adv          = 1'b1;
        cfg_c.fast_full_duplex = 1'b1;
        cfg_c.fast_half_duplex = 1'b1;
        cfg_c.ten_full_duplex  = 1'b1;
        cfg_c.ten_half_duplex  = 1'b1;
      end
      default: begin
        // Reserved code: flagged invalid, ports parked powered down.
        cfg_c                = '0;
        cfg_c.power_down     = 1'b1;
        cfg_c.pll_enable     = 1'b1;
      end
    endcase
  end

  // Hand the settings back.
  assign bus.cfg = cfg_c;

endmodule

// ### verilog/sml_strap_latch.sv
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - Straps captured on the third clock edge after reset release, then held.
// - Five-bit mode field sets all ports.
// - Code 01000: power-down, PLL kept running.
// - 01010/01011 force gigabit master or 100 full.
// - Gigabit half duplex is never advertised.
// - 10000 advertises all but EEE, cat3, single.
// - 0x18/0x19 advertise all speeds with EEE.
module sml_strap_latch #(
  parameter int unsigned NUM_PORTS = 4
) (
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output      logic                            hreadyout,
  output      logic [31:0]                     hrdata,
  output      logic                            hresp,
  input  wire logic [sml_pkg::SML_MODE_W-1:0]  mode_strap,
  output      sml_pkg::sml_cfg_s               cfg,
  output      logic [NUM_PORTS-1:0]            port_power_down,
  output      logic                            cfg_latched
);
  import sml_pkg::*;

  // Strap synchroniser stages; only the second stage is read by logic.
  logic     [SML_MODE_W-1:0] sync1_q;
  logic     [SML_MODE_W-1:0] sync2_q;
  // Cycles elapsed since reset release, saturating at the settle count.
  logic     [1:0]            settle_q;
  // Set once the straps have been captured; never clears until reset.
  logic                      latched_q;
  // Held mode code and its decoded settings.
  logic     [SML_MODE_W-1:0] mode_q;
  sml_cfg_s                  cfg_q;
  // Capture strobe, one cycle wide.
  logic                      capture;

  // Software power-down mask, one bit per port.
  logic     [NUM_PORTS-1:0]  pdown_q;
  logic     [NUM_PORTS-1:0]  pdown_d;
  // Port power-down outputs.
  logic     [NUM_PORTS-1:0]  port_pd_q;

  // Bus data-phase state for a pending write, and the registered read data.
  logic                      wr_q;
  logic     [SML_ADDR_W-1:0] waddr_q;
  logic     [31:0]           rdata_q;

  // Link to the decoder.
  sml_cfg_if cfg_bus ();

  // Decoder for the code being captured or held.
  sml_mode_decode u_decode (
    .bus (cfg_bus.dec)
  );

  // The decoder sees the synchronised pins until capture, then the held code.
  assign cfg_bus.mode = latched_q ? mode_q : sync2_q;

  // Capture happens once, after the synchroniser has filled with pin data.
  assign capture = ~latched_q && (settle_q == SML_SETTLE_CYC);

  // Two-flop synchroniser for the strap pins; the board is trusted to hold
  // them steady across the release, so all bits arrive together.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= SML_MODE_RST;
      sync2_q <= SML_MODE_RST;
    end else begin
      sync1_q <= mode_strap;
      sync2_q <= sync1_q;
    end
  end

  // Settle counter; it stops once the capture count is reached.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= 2'h0;
    end else if (settle_q != SML_SETTLE_CYC) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Capture the code and its settings, then hold both until next reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched_q <= 1'b0;
      mode_q    <= SML_MODE_RST;
      cfg_q     <= '0;
    end else if (capture) begin
      latched_q <= 1'b1;
      mode_q    <= sync2_q;
      cfg_q     <= cfg_bus.cfg;
    end
  end

  // Ports power down by mode or by the software mask.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_pd_q <= '0;
    end else begin
      port_pd_q <= {NUM_PORTS{cfg_q.power_down}} | pdown_q;
    end
  end

  assign cfg             = cfg_q;
  assign port_power_down = port_pd_q;
  assign cfg_latched     = latched_q;

  // ---- AHB-Lite slave: zero wait states, always OKAY. ----

  // Address-phase decode of a valid transfer; only writes must be word-sized.
  wire                  xfer   = hsel && htrans[1] && hready;
  wire                  wr_req = xfer && hwrite && (hsize == SML_HSIZE_WORD);
  wire                  rd_req = xfer && !hwrite;
  wire [SML_ADDR_W-1:0] aofs   = haddr[SML_ADDR_W-1:0];

  // Write data lands in the data phase; the next value is also forwarded
  // to a read whose address phase overlaps that data phase.
  assign pdown_d = (wr_q && (waddr_q == SML_OFS_PDOWN)) ?
                   hwdata[NUM_PORTS-1:0] : pdown_q;

  // Read words for each mapped register; unused bits read as zero.
  wire [31:0] st_word  = {25'h0, latched_q, cfg_q.mode_valid, mode_q};
  wire [31:0] cfg_word = {{(32-SML_CFG_W){1'b0}}, cfg_q};
  wire [31:0] pd_word  = {{(32-NUM_PORTS){1'b0}}, pdown_d};

  // Read select; an unmapped offset reads as zero.
  wire [31:0] rd_word = (aofs == SML_OFS_STATUS) ? st_word  :
                        (aofs == SML_OFS_CFG)    ? cfg_word :
                        (aofs == SML_OFS_PDOWN)  ? pd_word  : 32'h0;

  // Remember a write for its data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      waddr_q <= '0;
    end else begin
      wr_q    <= wr_req;
      waddr_q <= aofs;
    end
  end

  // Read data is registered at the end of the address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0;
    end else if (rd_req) begin
      rdata_q <= rd_word;
    end
  end

  // Software power-down mask.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdown_q <= '0;
    end else begin
      pdown_q <= pdown_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // ---- Checks placed beside the logic they guard. ----

  // Capture takes exactly the value that the synchroniser presented.
  a_capture_value: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(latched_q) |-> (mode_q == $past(sync2_q))
  ) else $error("Captured mode differs from synchronised straps.");

  // Capture happens on the third edge after reset release.
  a_capture_time: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (settle_q == 2'h0) |-> ##3 latched_q
  ) else $error("Straps not captured three edges after release.");

  // Once captured, code and settings never change.
  a_held_config: assert property (
    @(posedge hclk) disable iff (!hresetn)
    latched_q |=> (latched_q && $stable(mode_q) && $stable(cfg_q))
  ) else $error("Held configuration changed after capture.");

  // Power-down mode reaches every port output on the following edge.
  a_pdown_mode: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && mode_q == SML_MODE_PDOWN) |=>
      (&port_power_down && cfg_q.pll_enable && !cfg_q.aneg_enable)
  ) else $error("Power-down mode not applied with PLL running.");

  // Forced codes switch off negotiation, crossover and EEE.
  a_forced_link: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && (mode_q == SML_MODE_FORCE_GIG ||
                   mode_q == SML_MODE_FORCE_FST)) |->
      (!cfg_q.aneg_enable && !cfg_q.auto_crossover && !cfg_q.eee_adv &&
       (cfg_q.force_gig == cfg_q.force_master) &&
       (cfg_q.force_fast == mode_q[0]) && (cfg_q.force_gig != mode_q[0]))
  ) else $error("Forced link mode decoded wrongly.");

  // Gigabit half duplex stays off whatever the code.
  a_no_gig_half: assert property (
    @(posedge hclk) disable iff (!hresetn)
    latched_q |-> !cfg_q.gig_half_duplex
  ) else $error("Gigabit half duplex advertised.");

  // Code 10000 gives the full set without EEE, cat3, single port.
  a_aneg_base: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && mode_q == SML_MODE_AN_ALL_S) |->
      (cfg_q.aneg_enable && cfg_q.gig_full_duplex && !cfg_q.multi_port &&
       cfg_q.fast_full_duplex && cfg_q.fast_half_duplex &&
       cfg_q.ten_full_duplex && cfg_q.ten_half_duplex && cfg_q.pause_adv &&
       cfg_q.cat3_cable && cfg_q.auto_crossover && !cfg_q.eee_adv)
  ) else $error("Code 10000 advertisement wrong.");

  // Default codes advertise everything with EEE and the port preference.
  a_eee_default: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && (mode_q == SML_MODE_EEE_S || mode_q == SML_MODE_EEE_M))
      |-> (cfg_q.eee_adv && cfg_q.gig_full_duplex &&
           cfg_q.fast_full_duplex && cfg_q.fast_half_duplex &&
           cfg_q.ten_full_duplex && cfg_q.ten_half_duplex &&
           (cfg_q.multi_port == mode_q[0]) && !cfg_q.cat3_cable)
  ) else $error("Default EEE advertisement wrong.");

  // The 100-only codes advertise neither 1000 full nor 10 full duplex.
  a_aneg_subset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && mode_q[4:1] == SML_MODE_AN_FST[4:1]) |->
      (cfg_q.fast_full_duplex && (cfg_q.fast_half_duplex != mode_q[0]) &&
       !cfg_q.gig_full_duplex && !cfg_q.ten_full_duplex &&
       cfg_q.pause_adv && cfg_q.auto_crossover)
  ) else $error("Code 10100 or 10101 advertisement wrong.");

  // Reserved codes 0x00-0x07 and 0x09 are flagged invalid and keep the ports down.
  a_reserved_mode: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && (mode_q == 5'h09 || mode_q[4:3] == 2'h0)) |->
      (!cfg_q.mode_valid && cfg_q.power_down)
  ) else $error("Reserved mode not flagged invalid.");

  // Code 10001 is the 10000 set with the multi-port preference.
  a_aneg_multi: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && mode_q == SML_MODE_AN_ALL_M) |->
      (cfg_q.aneg_enable && cfg_q.gig_full_duplex && cfg_q.multi_port &&
       cfg_q.fast_full_duplex && cfg_q.fast_half_duplex &&
       cfg_q.ten_full_duplex && cfg_q.ten_half_duplex && cfg_q.pause_adv &&
       cfg_q.cat3_cable && cfg_q.auto_crossover && !cfg_q.eee_adv)
  ) else $error("Code 10001 advertisement wrong.");

  // Gigabit-only codes advertise no slower speed and keep the preference.
  a_gig_subset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && mode_q[4:1] == SML_MODE_AN_GIG_S[4:1]) |->
      (cfg_q.gig_full_duplex && (cfg_q.multi_port == mode_q[0]) &&
       !cfg_q.fast_full_duplex && !cfg_q.fast_half_duplex &&
       !cfg_q.ten_full_duplex && !cfg_q.ten_half_duplex &&
       !cfg_q.eee_adv && cfg_q.pause_adv && cfg_q.auto_crossover)
  ) else $error("Code 10010 or 10011 advertisement wrong.");

  // Until capture the settings and the held code read as all zero.
  a_idle_before: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !latched_q |-> (cfg_q == '0 && mode_q == SML_MODE_RST)
  ) else $error("Settings changed before the straps were captured.");

  // Reserved codes hold every port powered down from the next edge.
  a_reserved_ports: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (latched_q && !cfg_q.mode_valid) |=> &port_power_down
  ) else $error("Reserved mode left a port powered up.");

  // Port pins follow the mode's power-down and the mask one edge later.
  a_port_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |=> (port_power_down ==
              ({NUM_PORTS{$past(cfg_q.power_down)}} | $past(pdown_q)))
  ) else $error("Port power-down pins do not follow mode and mask.");

  // A word write to the mask register lands on the data-phase edge.
  a_pdown_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_q && waddr_q == SML_OFS_PDOWN) |=>
      (pdown_q == $past(hwdata[NUM_PORTS-1:0]))
  ) else $error("Power-down mask write lost.");

endmodule

// ### tb/sml_strap_board.sv
`timescale 1ns/10ps
// Board strap resistors as the device sees them at its mode pins.
module sml_strap_board (
  input  wire logic       hresetn,    // Pin reset from the reset source.
  input  wire logic [4:0] want,       // Level the board is built for.
  input  wire logic       late_move,  // Scenario moves straps after capture.
  output      logic [4:0] mode_strap  // Levels at the strap pins.
);
  // Straps settle only while reset is held, so they are steady at release;
  // a scenario may move them later to show that the capture holds.
  always_latch begin
    if (!hresetn || late_move) begin
      mode_strap <= want;
    end
  end
endmodule

// ### tb/test_strap_mode_latch_decoder.sv
`timescale 1ns/10ps
// Walks every mode code through a reset and checks settings and registers.
module test_strap_mode_latch_decoder;
  import sml_pkg::*;
  localparam int NP = 4;               // Ports built into the device.
  logic           hclk, hresetn, hsel; // Clock, reset and slave select.
  logic [31:0]    haddr, hwdata;       // Address and write data.
  logic [31:0]    hrdata;              // Read data from the device.
  logic [1:0]     htrans;              // Transfer type.
  logic [2:0]     hsize;               // Transfer size.
  logic           hwrite, hready;      // Direction and bus ready.
  logic           hreadyout, hresp;    // Slave answer.
  logic [4:0]     want, mode_strap;    // Board level and pin level.
  logic           late_move;           // Lets straps move after capture.
  sml_cfg_s       cfg;                 // Decoded settings.
  logic [NP-1:0]  port_power_down;     // Per-port power-down pins.
  logic           cfg_latched;         // Capture done.
  int             n_mismatch, checked; // Result counters.
  int             seed = 32'h7a72f13d; // Fixed seed for masks.

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;
  // Free-running bus clock.
  always #2 hclk = ~hclk;

  sml_strap_latch #(.NUM_PORTS(NP)) u_sml_strap_latch (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .mode_strap(mode_strap), .cfg(cfg),
    .port_power_down(port_power_down), .cfg_latched(cfg_latched));

  sml_strap_board u_sml_strap_board (
    .hresetn(hresetn), .want(want), .late_move(late_move),
    .mode_strap(mode_strap));

  // Expected settings for a code, worked out independently.
  function automatic sml_cfg_s exp_cfg(input int code);
    sml_cfg_s c;
    c = '0;
    c.pll_enable = 1'b1;
    case (code)
      8: begin
        c.mode_valid = 1'b1;
        c.power_down = 1'b1;
      end
      10: begin
        c.mode_valid = 1'b1;
        c.force_gig = 1'b1;
        c.force_master = 1'b1;
      end
      11: begin
        c.mode_valid = 1'b1;
        c.force_fast = 1'b1;
      end
      16, 17, 18, 19, 20, 21, 24, 25: begin
        c.mode_valid = 1'b1;
        c.aneg_enable = 1'b1;
        c.auto_crossover = 1'b1;
        c.pause_adv = 1'b1;
        c.multi_port = code inside {17, 19, 25};
        c.gig_full_duplex = code inside {[16:19], 24, 25};
        c.fast_full_duplex = code inside {16, 17, 20, 21, 24, 25};
        c.fast_half_duplex = code inside {16, 17, 20, 24, 25};
        c.ten_full_duplex = code inside {16, 17, 24, 25};
        c.ten_half_duplex = code inside {16, 17, 24, 25};
        c.cat3_cable = code < 18;
        c.eee_adv = code > 23;
      end
      // Reserved and unimplemented codes are flagged invalid.
      default: c.power_down = 1'b1;
    endcase
    return c;
  endfunction

  // Compares one value and reports a difference.
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Waits, with a bound, for a rising edge that samples ready high.
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("hready", 32'h0, 32'h1);
    end
  endtask

  // One single AHB-Lite transfer: address phase, then data phase.
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [2:0] sz, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // Reads a word and compares it.
  task automatic rd_chk(input string what, input logic [31:0] a,
                        input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, a, 3'h2, 32'h0, rd);
    chk(what, rd, exp);
  endtask

  // Straps a code, pulses reset and checks what the device captured.
  task automatic run_code(input int code);
    sml_cfg_s e;
    e = exp_cfg(code);
    hresetn <= 1'b0;
    want <= code[4:0];
    repeat (2) @(posedge hclk);
    chk("latched in reset", {31'h0, cfg_latched}, 32'h0);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("cfg", {14'h0, cfg}, {14'h0, e});
    chk("gig half", {31'h0, cfg.gig_half_duplex}, 32'h0);
    chk("latched", {31'h0, cfg_latched}, 32'h1);
    chk("pd pins", {28'h0, port_power_down},
        {28'h0, {NP{e.power_down}}});
    rd_chk("status", 32'h0, {25'h0, 1'b1, e.mode_valid, code[4:0]});
    rd_chk("cfg reg", 32'h4, {14'h0, e});
    late_move <= 1'b1;
    want <= ~code[4:0];
    repeat (5) @(posedge hclk);
    chk("held cfg", {14'h0, cfg}, {14'h0, e});
    late_move <= 1'b0;
  endtask

  // Random masks through the power-down register, with refused writes.
  task automatic pdown_test;
    logic [31:0] m, rd;
    int          mask_m;   // Model of the mask register after each write.
    int          exp_q[$]; // Read-backs that the model expects, in order.
    mask_m = 0;
    for (int k = 0; k < 3; k++) begin
      m = $random(seed);
      xfer(1'b1, 32'h8, 3'h2, m, rd);
      mask_m = int'(m[3:0]);
      exp_q.push_back(mask_m);
      rd_chk("pdown reg", 32'h8, exp_q.pop_front());
      chk("pd pins", {28'h0, port_power_down}, mask_m);
      xfer(1'b1, 32'h8, 3'h0, ~m, rd);
      exp_q.push_back(mask_m);
      rd_chk("pdown byte", 32'h8, exp_q.pop_front());
      xfer(1'b1, 32'h0, 3'h2, ~m, rd);
      rd_chk("status ro", 32'h0, 32'h70);
      rd_chk("unmapped", {24'h0, 4'($random(seed)) | 4'h3, 4'hc}, 32'h0);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: every code including 0x18 and 0x19, then the register.
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    want = 5'h18;
    late_move = 1'b0;
    for (int k = 0; k < 32; k++) begin
      run_code(k);
    end
    $display("test all mode codes done");
    run_code(16);
    pdown_test();
    $display("test power-down register done");
    give_verdict();
  end

  // Watchdog: the tests need about 600 cycles.
  initial begin
    repeat (6000) @(posedge hclk);
    chk("watchdog", 32'h1, 32'h0);
    give_verdict();
  end
endmodule
